// file: common/srfc_consts.vh
`ifndef SRFC_CONSTS_VH
`define SRFC_CONSTS_VH
// Register byte offsets on the Avalon-MM slave.
`define SRFC_OFS_CTRL 4'h0
`define SRFC_OFS_STAT 4'h4
`define SRFC_OFS_RXDATA 4'h8
`define SRFC_OFS_TXDATA 4'hc
// Control register fields.
`define SRFC_CTRL_XON_BIT 0
`define SRFC_CTRL_PASS_BIT 1
`define SRFC_CTRL_RESET 2'h0
// Configuration defaults: serial-controller mode, 7 data, 1 stop, no parity.
`define SRFC_DEF_MODE 1'h0
`define SRFC_DEF_BAUD 3'h5
`define SRFC_DEF_BITS8 1'h0
`define SRFC_DEF_STOP2 1'h0
`define SRFC_DEF_PAREN 1'h0
// Flow-control characters.
`define SRFC_CHAR_XOFF 8'h13
`define SRFC_CHAR_XON 8'h11
// Buffer geometry and levels.
`define SRFC_FIFO_DEPTH 8
`define SRFC_FIFO_AW 3
`define SRFC_ALMOST_FULL 4'h5
`define SRFC_ALMOST_EMPTY 4'h2
// Timing.
`define SRFC_CLK_HZ 100000000
`define SRFC_BAUD_BASE 300
`define SRFC_READY_MS 7000
`define SRFC_SELFTEST_CYC 32'd100000
`endif

// file: rtl/srfc_fifo.v
`default_nettype none
module srfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock_i,
  input wire rst_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [AW:0] level_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_reg != DEPTH);
  assign out_valid_o = (cnt_reg != 0);
  assign out_data_o = mem[rd_reg];
  assign level_o = cnt_reg;
  always @(posedge clock_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
    if (rst_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // srfc_fifo
`default_nettype wire

// file: rtl/srfc_top.v
// What this block does
// - Received data bytes are buffered until the parallel side takes them; a byte arriving at a full buffer is dropped.
// - RTS/CTS hardware handshaking stays active regardless of the software setting.
// - RTS is asserted while the block is ready and the buffer is not throttled at the almost-full level.
// - RTS drops once the buffer reaches the almost-full level.
// - RTS returns after the buffer drains to the almost-empty level.
// - The transmitter ends the frame in progress when CTS drops, and starts no data byte until it returns.
// - XON/XOFF stays off until software enables it.
// - With XON/XOFF on, send stop character 19 before the buffer overflows.
// - With XON/XOFF on, send resume character 17 when able to accept again.
// - Without parity, a received stop character halts data-byte transmit (flow characters still go out) until resume character arrives.
// - Reset defaults: controller mode, 7 data, 1 stop, no parity, 9600 baud.
// - Power indicator turns on immediately after power-up.
// - Ready indicator turns on only after self-test, within seven seconds.
// - A three-bit code selects 300 to 38400 baud in doubling steps.
`include "srfc_consts.vh"
`default_nettype none
module srfc_top #(
  parameter [31:0] SELFTEST_CYC = `SRFC_SELFTEST_CYC,
  parameter [3:0] ALMOST_FULL = `SRFC_ALMOST_FULL,
  parameter [3:0] ALMOST_EMPTY = `SRFC_ALMOST_EMPTY
) (
  input wire clock_i,
  input wire rst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire rxd_i,
  output reg txd_o,
  input wire cts_i,
  output reg rts_o,
  input wire [2:0] baud_sel_i,
  input wire mode_sel_i,
  input wire bits8_i,
  input wire stop2_i,
  input wire par_en_i,
  input wire par_even_i,
  output reg power_led_o,
  output reg ready_led_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_STOP = 2'h2;
  localparam ST_START = 2'h3;
  localparam [31:0] SLOW_DIV = `SRFC_CLK_HZ / (`SRFC_BAUD_BASE * 16);

  // Tick spacing for 16x oversampling at the selected rate.
  function [31:0] div_for;
    input [2:0] code;
    begin
      div_for = SLOW_DIV >> code;
    end
  endfunction

  function parity_of;
    input [7:0] d;
    input b8;
    input even;
    begin
      parity_of = (^(b8 ? d : {1'b0, d[6:0]})) ^ ~even;
    end
  endfunction

  reg rxd_s1_reg, rxd_s2_reg, cts_s1_reg, cts_s2_reg;
  reg [2:0] baud_reg;
  reg mode_reg, bits8_reg, stop2_reg, paren_reg, pareven_reg;
  reg xon_en_reg, pass_reg;
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg [31:0] post_cnt_reg;
  reg [1:0] rx_st_reg;
  reg [3:0] rx_sub_reg;
  reg [3:0] rx_bit_reg;
  reg [9:0] rx_sh_reg;
  reg rx_push_reg;
  reg [7:0] rx_byte_reg;
  reg peer_stopped_reg;
  reg throttle_reg;
  reg send_xoff_reg, send_xon_reg;
  reg [1:0] tx_st_reg;
  reg [3:0] tx_sub_reg;
  reg [3:0] tx_bit_reg;
  reg [10:0] tx_sh_reg;
  reg [7:0] tx_hold_reg;
  reg tx_hold_full_reg;
  reg pop_reg;
  wire fifo_in_ready;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire [3:0] fifo_level;
  wire [3:0] nbits = bits8_reg ? 4'h8 : 4'h7;
  wire [3:0] frame_len = nbits + {3'h0, paren_reg} + {3'h0, stop2_reg} + 4'h1;
  wire is_ctrl = xon_en_reg && !pass_reg;

  srfc_fifo #(.WIDTH(8), .DEPTH(`SRFC_FIFO_DEPTH), .AW(`SRFC_FIFO_AW)) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_data_i(rx_byte_reg),
    .in_valid_i(rx_push_reg),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop_reg),
    .level_o(fifo_level)
  );

  always @(posedge clock_i) begin
    rxd_s1_reg <= rxd_i;
    rxd_s2_reg <= rxd_s1_reg;
    cts_s1_reg <= cts_i;
    cts_s2_reg <= cts_s1_reg;
    if (rst_i) begin
      baud_reg <= `SRFC_DEF_BAUD;
      mode_reg <= `SRFC_DEF_MODE;
      bits8_reg <= `SRFC_DEF_BITS8;
      stop2_reg <= `SRFC_DEF_STOP2;
      paren_reg <= `SRFC_DEF_PAREN;
      pareven_reg <= 1'b0;
      xon_en_reg <= 1'b0;
      pass_reg <= 1'b0;
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
      post_cnt_reg <= 32'h0;
      power_led_o <= 1'b1;
      ready_led_o <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
      rx_st_reg <= ST_IDLE;
      rx_sub_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 10'h0;
      rx_push_reg <= 1'b0;
      rx_byte_reg <= 8'h0;
      peer_stopped_reg <= 1'b0;
      throttle_reg <= 1'b0;
      send_xoff_reg <= 1'b0;
      send_xon_reg <= 1'b0;
      rts_o <= 1'b0;
      tx_st_reg <= ST_IDLE;
      tx_sub_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 11'h7ff;
      txd_o <= 1'b1;
      tx_hold_reg <= 8'h0;
      tx_hold_full_reg <= 1'b0;
      pop_reg <= 1'b0;
    end else begin
      power_led_o <= 1'b1;
      // Self-test is a fixed settle delay; it must stay well under seven seconds.
      if (!ready_led_o) begin
        if (post_cnt_reg == SELFTEST_CYC - 32'h1) begin
          ready_led_o <= 1'b1;
          baud_reg <= baud_sel_i;
          mode_reg <= mode_sel_i;
          bits8_reg <= bits8_i;
          stop2_reg <= stop2_i;
          paren_reg <= par_en_i;
          pareven_reg <= par_even_i;
        end else begin
          post_cnt_reg <= post_cnt_reg + 32'h1;
        end
      end
      if (tick_cnt_reg >= div_for(baud_reg) - 32'h1) begin
        tick_cnt_reg <= 32'h0;
        tick_reg <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
        tick_reg <= 1'b0;
      end
      // Bus slave: one wait cycle, then the answer with waitrequest low.
      pop_reg <= 1'b0;
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= 32'h0;
        if (avs_read_i) begin
          if (avs_address_i == `SRFC_OFS_CTRL) begin
            avs_readdata_o <= {30'h0, pass_reg, xon_en_reg};
          end else if (avs_address_i == `SRFC_OFS_STAT) begin
            avs_readdata_o <= {16'h0, 4'h0, fifo_level, peer_stopped_reg, throttle_reg,
                               rts_o, cts_s2_reg, tx_hold_full_reg, fifo_valid,
                               mode_reg, ready_led_o};
          end else if (avs_address_i == `SRFC_OFS_RXDATA) begin
            avs_readdata_o <= {23'h0, fifo_valid, fifo_data};
            pop_reg <= fifo_valid;
          end
        end else if (avs_address_i == `SRFC_OFS_CTRL) begin
          xon_en_reg <= avs_writedata_i[`SRFC_CTRL_XON_BIT];
          pass_reg <= avs_writedata_i[`SRFC_CTRL_PASS_BIT];
        end else if (avs_address_i == `SRFC_OFS_TXDATA && !tx_hold_full_reg) begin
          tx_hold_reg <= avs_writedata_i[7:0];
          tx_hold_full_reg <= 1'b1;
        end
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
      // Threshold hysteresis; the gap above almost-full absorbs in-flight bytes.
      if (fifo_level >= ALMOST_FULL) begin
        throttle_reg <= 1'b1;
        if (!throttle_reg && xon_en_reg) begin
          send_xoff_reg <= 1'b1;
        end
      end else if (fifo_level <= ALMOST_EMPTY && throttle_reg) begin
        throttle_reg <= 1'b0;
        if (xon_en_reg) begin
          send_xon_reg <= 1'b1;
        end
      end
      rts_o <= ready_led_o && !throttle_reg;
      rx_push_reg <= 1'b0;
      if (tick_reg) begin
        case (rx_st_reg)
          ST_IDLE: begin
            if (!rxd_s2_reg) begin
              rx_st_reg <= ST_START;
              rx_sub_reg <= 4'h0;
            end
          end
          ST_START: begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == 4'h7) begin
              rx_sub_reg <= 4'h0;
              rx_bit_reg <= 4'h0;
              rx_st_reg <= rxd_s2_reg ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == 4'hf) begin
              rx_sh_reg <= {rxd_s2_reg, rx_sh_reg[9:1]};
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == nbits + {3'h0, paren_reg} - 4'h1) begin
                rx_st_reg <= ST_STOP;
              end
            end
          end
          default: begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == 4'hf) begin
              rx_st_reg <= ST_IDLE;
              rx_byte_reg <= paren_reg ? (bits8_reg ? rx_sh_reg[8:1] : {1'b0, rx_sh_reg[8:2]})
                : (bits8_reg ? rx_sh_reg[9:2] : {1'b0, rx_sh_reg[9:3]});
              if (is_ctrl && rx_byte_reg_next_is(`SRFC_CHAR_XOFF)) begin
                peer_stopped_reg <= 1'b1;
              end else if (is_ctrl && rx_byte_reg_next_is(`SRFC_CHAR_XON)) begin
                peer_stopped_reg <= 1'b0;
              end else if (fifo_in_ready) begin
                rx_push_reg <= 1'b1;
              end
            end
          end
        endcase
      end
      if (!xon_en_reg) begin
        peer_stopped_reg <= 1'b0;
      end
      // Transmitter: a frame in progress ends cleanly; CTS gates the next data start, not flow characters.
      if (tick_reg) begin
        if (tx_st_reg == ST_IDLE) begin
          if (send_xoff_reg || send_xon_reg) begin
            tx_sh_reg <= {2'h3, send_xoff_reg ? `SRFC_CHAR_XOFF : `SRFC_CHAR_XON, 1'b0}
              | {2'h0, ~bits8_reg, 8'h00};
            send_xoff_reg <= 1'b0;
            send_xon_reg <= send_xoff_reg ? send_xon_reg : 1'b0;
            tx_st_reg <= ST_DATA;
            tx_sub_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
          end else if (tx_hold_full_reg && cts_s2_reg && !peer_stopped_reg) begin
            tx_sh_reg <= paren_reg
              ? {1'b1, parity_of(tx_hold_reg, bits8_reg, pareven_reg), tx_hold_reg, 1'b0}
              : {2'h3, tx_hold_reg, 1'b0};
            if (!bits8_reg) begin
              tx_sh_reg <= paren_reg
                ? {2'h3, parity_of(tx_hold_reg, 1'b0, pareven_reg), tx_hold_reg[6:0], 1'b0}
                : {3'h7, tx_hold_reg[6:0], 1'b0};
            end
            tx_hold_full_reg <= 1'b0;
            tx_st_reg <= ST_DATA;
            tx_sub_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
          end
        end else begin
          tx_sub_reg <= tx_sub_reg + 4'h1;
          txd_o <= tx_sh_reg[0];
          if (tx_sub_reg == 4'hf) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == frame_len) begin
              tx_st_reg <= ST_IDLE;
              txd_o <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Received character taken from the shift register before it is latched.
  function rx_byte_reg_next_is;
    input [7:0] c;
    begin
      rx_byte_reg_next_is = ({1'b0, rx_sh_reg[9:3]} == c) ||
        (bits8_reg && rx_sh_reg[9:2] == c);
    end
  endfunction
endmodule // srfc_top
`default_nettype wire

// file: bench/srfc_top_properties.sv
`default_nettype none
module srfc_top_props #(
  parameter [31:0] SELFTEST_CYC = 32'd10
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic txd_o,
  input wire logic rts_o,
  input wire logic [2:0] baud_sel_i,
  input wire logic power_led_o,
  input wire logic ready_led_o
);
  logic [31:0] cnt;
  logic [31:0] run;
  logic txd_q;
  wire logic [31:0] bit_min;
  // The margin absorbs rounding of the tick divider, not a short bit.
  assign bit_min = 32'd16 * (32'd20833 >> baud_sel_i) - 32'd32;
  always @(posedge clock_i) begin
    txd_q <= txd_o;
    if (rst_i) begin
      cnt <= 32'h0;
      run <= 32'h0010_0000;
    end else begin
      cnt <= cnt + 32'h1;
      run <= (txd_o != txd_q) ? 32'h1 : run + 32'h1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_power; power_led_o; endproperty
  a_power: assert property (p_power) else $error("power indicator low");
  property p_ready_early; ready_led_o |-> cnt + 32'd2 >= SELFTEST_CYC; endproperty
  a_ready_early: assert property (p_ready_early) else $error("ready too early");
  property p_ready_late; cnt >= SELFTEST_CYC + 32'd2 |-> ready_led_o; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too late");
  property p_rts_ready; rts_o |-> ready_led_o; endproperty
  a_rts_ready: assert property (p_rts_ready) else $error("rts before ready");
  property p_rts_rise; $rose(ready_led_o) |-> ##[0:2] rts_o; endproperty
  a_rts_rise: assert property (p_rts_rise) else $error("rts not raised");
  property p_bit_len; txd_o != txd_q |-> run >= bit_min; endproperty
  a_bit_len: assert property (p_bit_len) else $error("serial bit too short");
  property p_answer; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bus not answered");
  property p_answer_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_answer_one: assert property (p_answer_one) else $error("answer too long");
endmodule // srfc_top_props
bind srfc_top srfc_top_props #(.SELFTEST_CYC(SELFTEST_CYC)) u_props (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .txd_o(txd_o),
  .rts_o(rts_o),
  .baud_sel_i(baud_sel_i),
  .power_led_o(power_led_o),
  .ready_led_o(ready_led_o)
);
`default_nettype wire

// file: bench/srfc_peer.sv
`default_nettype none
module srfc_peer #(
  parameter int BIT = 2592
) (
  input wire logic clock_i,
  input wire logic txd_i,
  input wire logic rts_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial rxd_o = 1'b1;
  // Only 7-bit characters are sent; the flow characters are sent through this same task.
  task automatic send(input logic [6:0] b);
    logic [8:0] frame;
    frame = {1'b1, b, 1'b0};
    while (rts_i !== 1'b1) @(posedge clock_i);
    for (int i = 0; i < 9; i++) begin
      rxd_o <= frame[i];
      repeat (BIT) @(posedge clock_i);
    end
  endtask
  always @(negedge txd_i) begin : rx
    logic [6:0] d;
    repeat (BIT / 2) @(posedge clock_i);
    if (txd_i === 1'b0) begin
      for (int i = 0; i < 7; i++) begin
        repeat (BIT) @(posedge clock_i);
        d[i] = txd_i;
      end
      repeat (BIT) @(posedge clock_i);
      if (txd_i === 1'b1) got.push_back({1'b0, d});
    end
  end
endmodule // srfc_peer
`default_nettype wire

// file: bench/srfc_top_tb.sv
`include "srfc_consts.vh"
`default_nettype none
module srfc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 2592;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic rxd_i;
  logic txd_o;
  logic cts_i = 1'b0;
  logic rts_o;
  logic [2:0] baud_sel_i = 3'h7;
  logic [4:0] straps = 5'h0;
  logic power_led_o;
  logic ready_led_o;
  logic [31:0] rd;
  int mismatches = 0;
  int n_tests = 0;
  int k;
  always #5 clock_i = ~clock_i;
  // Short thresholds keep each throttle cycle to one serial frame.
  srfc_top #(.SELFTEST_CYC(32'd10), .ALMOST_FULL(4'h1), .ALMOST_EMPTY(4'h0)) uut (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .rxd_i(rxd_i),
    .txd_o(txd_o),
    .cts_i(cts_i),
    .rts_o(rts_o),
    .baud_sel_i(baud_sel_i),
    .mode_sel_i(straps[4]),
    .bits8_i(straps[3]),
    .stop2_i(straps[2]),
    .par_en_i(straps[1]),
    .par_even_i(straps[0]),
    .power_led_o(power_led_o),
    .ready_led_o(ready_led_o)
  );
  srfc_peer #(.BIT(BIT)) u_peer (
    .clock_i(clock_i),
    .txd_i(txd_o),
    .rts_i(rts_o),
    .rxd_o(rxd_i)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    chk(avs_waitrequest_o, 32'h0);
  endtask
  task automatic wait_tx(input int n);
    for (k = 0; k < 60000 && u_peer.got.size() < n; k++) @(posedge clock_i);
    chk(u_peer.got.size(), n);
  endtask
  task end_sim;
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1500000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clock_i);
    chk({power_led_o, ready_led_o, rts_o, txd_o}, 32'h9);
    straps <= 5'h10;
    rst_i <= 1'b0;
    for (k = 0; k < 50 && ready_led_o !== 1'b1; k++) @(posedge clock_i);
    chk(ready_led_o, 32'h1);
    repeat (3) @(posedge clock_i);
    chk(rts_o, 32'h1);
    bus(1'b0, `SRFC_OFS_STAT, 32'h0);
    chk(rd[1:0], 32'h3);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `SRFC_OFS_CTRL, 32'h1);
    bus(1'b1, `SRFC_OFS_TXDATA, 32'h55);
    u_peer.send(7'h41);
    for (k = 0; k < 5000 && rts_o !== 1'b0; k++) @(posedge clock_i);
    chk(rts_o, 32'h0);
    wait_tx(1);
    chk(u_peer.got[0], `SRFC_CHAR_XOFF);
    bus(1'b0, `SRFC_OFS_RXDATA, 32'h0);
    chk(rd[8:0], 32'h141);
    bus(1'b0, `SRFC_OFS_RXDATA, 32'h0);
    chk(rd[8], 32'h0);
    for (k = 0; k < 5000 && rts_o !== 1'b1; k++) @(posedge clock_i);
    chk(rts_o, 32'h1);
    fork
      u_peer.send(7'h13);
      wait_tx(2);
    join
    chk(u_peer.got[1], `SRFC_CHAR_XON);
    repeat (BIT) @(posedge clock_i);
    bus(1'b0, `SRFC_OFS_STAT, 32'h0);
    chk({rd[7], rd[3]}, 32'h3);
    cts_i <= 1'b1;
    u_peer.send(7'h11);
    chk(u_peer.got.size(), 32'h2);
    wait_tx(3);
    chk(u_peer.got[2], 32'h55);
    end_sim;
  end
endmodule // srfc_top_tb
`default_nettype wire
